// ---- slphc_pkg.sv ----
// Package: constants and types for the sleep and host serial config block
package slphc_pkg;
    // ----------------------------------------
    // Parameter selectors
    // ----------------------------------------
    typedef enum logic [3:0] {
        SEL_SLEEP_MODE, SEL_SLEEP_OPT, SEL_IDLE_TIME, SEL_CYC_PERIOD,
        SEL_UNJ_PERIOD, SEL_SER_RATE, SEL_PKT_IDLE, SEL_FRAMING,
        SEL_PARITY, SEL_PULLUP
    } slphc_sel_t;

    typedef struct packed {
        slphc_sel_t sel;
        logic wr;
        logic rd;
        logic [31:0] data;
    } slphc_cfg_t;

    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [7:0] RST_SLEEP_MODE = 8'h00;
    localparam logic [7:0] RST_SLEEP_OPT = 8'h00;
    localparam logic [15:0] RST_IDLE_TIME = 16'h1388;
    localparam logic [15:0] RST_CYC_PERIOD = 16'h0000;
    localparam logic [15:0] RST_UNJ_PERIOD = 16'h03E8;
    localparam logic [31:0] RST_SER_RATE = 32'h0000_0003;
    localparam logic [7:0] RST_PKT_IDLE = 8'h03;
    localparam logic [7:0] RST_FRAMING = 8'h00;
    localparam logic [7:0] RST_PARITY = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'hFF;
    localparam logic [15:0] MAX_PERIOD = 16'h68B0;
    localparam logic [31:0] RATE_NS_MIN = 32'h0000_0080;
    localparam logic [31:0] RATE_NS_MAX = 32'h0003_D090;
    localparam logic [7:0] MODE_MAX = 8'h06;
    localparam logic [7:0] MODE_RSVD = 8'h03;
    localparam logic [7:0] MODE_CYC = 8'h04;
    localparam logic [7:0] MODE_CYC_PIN = 8'h05;
    localparam logic [7:0] MODE_HIB = 8'h01;
    localparam logic [7:0] MODE_DOZE = 8'h02;
    localparam logic [7:0] MODE_COORD = 8'h06;
    localparam logic [7:0] FRAMING_MAX = 8'h02;
    localparam logic [7:0] PARITY_MAX = 8'h04;
    localparam int OPT_NO_POLL = 0;
    localparam int OPT_NO_SAMPLE = 1;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int IDLE_UNIT_MS = 1;
    localparam int PERIOD_UNIT_MS = 10;
    localparam int MS_CYCLES = CLK_HZ / 1000 * IDLE_UNIT_MS;
    localparam int PERIOD_MS = PERIOD_UNIT_MS / IDLE_UNIT_MS;
    localparam int CHAR_BITS = 10;
    localparam int CHAR_BITS_PAR = 11;
endpackage

// ---- slphc_core.sv ----
// Module: sleep control and host serial configuration logic
// Function
// - Sleep mode 0 none, 1 hibernate pin, 2 doze pin, 4 cyclic, 5 cyclic+pin.
// - Mode 3 reserved and refused; mode 6 is the legacy coordinator setting.
// - Option bit 0 clear polls coordinator on each cyclic wake; set skips it.
// - Option bit 1 clear samples inputs on wake when sampling enabled.
// - Sleep only after idle interval, 1 ms units, 1 to 0xFFFF, default 0x1388.
// - Idle interval applies only in sleep modes 4 and 5.
// - Cyclic sleep period in 10 ms units, at most 0x68B0.
// - Cyclic sleep period 0 sends messages directly, not held indirect.
// - Coordinator holds indirect message 2.5 periods, then discards it.
// - Unassociated sleeper with association enabled uses unjoined period, 1 to 0x68B0, default 0x3E8.
// - Rate codes 0 to 7 pick 1200 to 115200 bps; default code 3.
// - Rate 0x80 to 0x3D090 is non-standard; readback gives achieved rate.
// - Buffered input sent after programmed idle character times, default 3.
// - Idle count zero sends each character as it arrives.
// - Framing 0 transparent, 1 framed, 2 framed with escapes.
// - Parity 0 none, 1 even, 2 odd, 3 mark, 4 space.
// - Pull-up bit 1 enables line pull-up; default 0xFF.
`timescale 1ns/1ps
`default_nettype none
module slphc_core #(
    parameter int MS_CLKS = slphc_pkg::MS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire slphc_pkg::slphc_cfg_t cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_err,
    input wire logic ser_rx_char,
    input wire logic ser_tx_char,
    input wire logic rf_rx_frame,
    input wire logic rf_tx_frame,
    input wire logic sleep_request_pin,
    input wire logic is_coordinator,
    input wire logic assoc_enabled,
    input wire logic associated,
    input wire logic sampling_en,
    input wire logic ind_msg_queued,
    input wire logic ind_msg_taken,
    output logic asleep,
    output logic deep_sleep,
    output logic poll_req,
    output logic sample_req,
    output logic direct_msgs,
    output logic ind_discard,
    output logic pkt_send,
    output logic legacy_coord,
    output logic [31:0] bit_clks,
    output logic [1:0] framing_mode,
    output logic [2:0] parity_mode,
    output logic [7:0] line_pullups
);
    import slphc_pkg::*;

    // ----------------------------------------
    // Configuration store
    // ----------------------------------------
    logic [7:0] sleep_mode_select_q, sleep_option_bits_q;
    logic [15:0] idle_before_sleep_time_q, cyclic_sleep_period_q;
    logic [15:0] unjoined_sleep_period_q;
    logic [31:0] host_serial_rate_q;
    logic [7:0] packet_idle_timeout_q, framing_mode_select_q;
    logic [7:0] parity_select_q, line_pullup_enables_q;
    logic [31:0] achieved_q, div_q;
    logic ok_d, rate_new_q;
    logic [31:0] wd;

    function automatic logic [31:0] std_rate(input logic [2:0] code);
        unique case (code)
            3'd0: std_rate = 32'd1200;
            3'd1: std_rate = 32'd2400;
            3'd2: std_rate = 32'd4800;
            3'd3: std_rate = 32'd9600;
            3'd4: std_rate = 32'd19200;
            3'd5: std_rate = 32'd38400;
            3'd6: std_rate = 32'd57600;
            3'd7: std_rate = 32'd115200;
        endcase
    endfunction

    function automatic logic period_ok(input logic [31:0] v);
        period_ok = (v != 32'd0) && (v <= {16'd0, MAX_PERIOD});
    endfunction

    assign wd = cfg_req.data;

    always_comb
    begin
        unique case (cfg_req.sel)
            SEL_SLEEP_MODE: ok_d = wd <= {24'd0, MODE_MAX} && wd != {24'd0, MODE_RSVD};
            SEL_SLEEP_OPT: ok_d = wd[31:8] == 24'd0;
            SEL_IDLE_TIME: ok_d = wd != 32'd0 && wd[31:16] == 16'd0;
            SEL_CYC_PERIOD: ok_d = wd <= {16'd0, MAX_PERIOD};
            SEL_UNJ_PERIOD: ok_d = period_ok(wd);
            SEL_SER_RATE: ok_d = wd < 32'd8 || (wd >= RATE_NS_MIN && wd <= RATE_NS_MAX);
            SEL_PKT_IDLE: ok_d = wd[31:8] == 24'd0;
            SEL_FRAMING: ok_d = wd <= {24'd0, FRAMING_MAX};
            SEL_PARITY: ok_d = wd <= {24'd0, PARITY_MAX};
            SEL_PULLUP: ok_d = wd[31:8] == 24'd0;
            default: ok_d = 1'b0;
        endcase
    end

    // Out-of-range writes leave the old value; host sees cfg_err
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sleep_mode_select_q <= RST_SLEEP_MODE;
            sleep_option_bits_q <= RST_SLEEP_OPT;
            idle_before_sleep_time_q <= RST_IDLE_TIME;
            cyclic_sleep_period_q <= RST_CYC_PERIOD;
            unjoined_sleep_period_q <= RST_UNJ_PERIOD;
            host_serial_rate_q <= RST_SER_RATE;
            packet_idle_timeout_q <= RST_PKT_IDLE;
            framing_mode_select_q <= RST_FRAMING;
            parity_select_q <= RST_PARITY;
            line_pullup_enables_q <= RST_PULLUP;
            rate_new_q <= 1'b1;
            cfg_err <= 1'b0;
        end
        else
        begin
            cfg_err <= cfg_req.wr && !ok_d;
            rate_new_q <= cfg_req.wr && ok_d && cfg_req.sel == SEL_SER_RATE;
            if (cfg_req.wr && ok_d)
            begin
                unique case (cfg_req.sel)
                    SEL_SLEEP_MODE: sleep_mode_select_q <= wd[7:0];
                    SEL_SLEEP_OPT: sleep_option_bits_q <= wd[7:0];
                    SEL_IDLE_TIME: idle_before_sleep_time_q <= wd[15:0];
                    SEL_CYC_PERIOD: cyclic_sleep_period_q <= wd[15:0];
                    SEL_UNJ_PERIOD: unjoined_sleep_period_q <= wd[15:0];
                    SEL_SER_RATE: host_serial_rate_q <= wd;
                    SEL_PKT_IDLE: packet_idle_timeout_q <= wd[7:0];
                    SEL_FRAMING: framing_mode_select_q <= wd[7:0];
                    SEL_PARITY: parity_select_q <= wd[7:0];
                    SEL_PULLUP: line_pullup_enables_q <= wd[7:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            cfg_rdata <= 32'd0;
        else if (cfg_req.rd)
        begin
            unique case (cfg_req.sel)
                SEL_SLEEP_MODE: cfg_rdata <= {24'd0, sleep_mode_select_q};
                SEL_SLEEP_OPT: cfg_rdata <= {24'd0, sleep_option_bits_q};
                SEL_IDLE_TIME: cfg_rdata <= {16'd0, idle_before_sleep_time_q};
                SEL_CYC_PERIOD: cfg_rdata <= {16'd0, cyclic_sleep_period_q};
                SEL_UNJ_PERIOD: cfg_rdata <= {16'd0, unjoined_sleep_period_q};
                SEL_SER_RATE: cfg_rdata <= host_serial_rate_q < 32'd8 ?
                    host_serial_rate_q : achieved_q;
                SEL_PKT_IDLE: cfg_rdata <= {24'd0, packet_idle_timeout_q};
                SEL_FRAMING: cfg_rdata <= {24'd0, framing_mode_select_q};
                SEL_PARITY: cfg_rdata <= {24'd0, parity_select_q};
                SEL_PULLUP: cfg_rdata <= {24'd0, line_pullup_enables_q};
                default: cfg_rdata <= 32'd0;
            endcase
        end
    end

    assign framing_mode = framing_mode_select_q[1:0];
    assign parity_mode = parity_select_q[2:0];
    assign line_pullups = line_pullup_enables_q;
    assign bit_clks = div_q;
    assign legacy_coord = sleep_mode_select_q == MODE_COORD;
    assign direct_msgs = cyclic_sleep_period_q == 16'd0;

    // ----------------------------------------
    // Rate divider: clocks per bit, then achieved rate
    // ----------------------------------------
    // Serial divider saves area; values settle 66 cycles after a write
    typedef enum {DV_IDLE, DV_DIV, DV_ACH} slphc_dv_t;
    slphc_dv_t dv_q;
    logic [31:0] num_q, den_q, quo_q, rem_q, rem_sh;
    logic [5:0] cnt_q;
    logic ge;

    assign rem_sh = {rem_q[30:0], num_q[31]};
    assign ge = rem_sh >= den_q;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            dv_q <= DV_IDLE;
            {num_q, den_q, quo_q, rem_q} <= '0;
            cnt_q <= 6'd0;
            div_q <= 32'd1;
            achieved_q <= 32'd0;
        end
        else
        begin
            unique case (dv_q)
                DV_IDLE:
                    if (rate_new_q)
                    begin
                        num_q <= 32'(CLK_HZ);
                        den_q <= host_serial_rate_q < 32'd8 ?
                            std_rate(host_serial_rate_q[2:0]) : host_serial_rate_q;
                        {quo_q, rem_q} <= '0;
                        cnt_q <= 6'd0;
                        dv_q <= DV_DIV;
                    end
                DV_DIV, DV_ACH:
                begin
                    num_q <= {num_q[30:0], 1'b0};
                    rem_q <= ge ? rem_sh - den_q : rem_sh;
                    quo_q <= {quo_q[30:0], ge};
                    cnt_q <= cnt_q + 6'd1;
                    if (cnt_q == 6'd31 && dv_q == DV_DIV)
                    begin
                        div_q <= {quo_q[30:0], ge};
                        num_q <= 32'(CLK_HZ);
                        den_q <= {quo_q[30:0], ge};
                        {quo_q, rem_q} <= '0;
                        cnt_q <= 6'd0;
                        dv_q <= DV_ACH;
                    end
                    else if (cnt_q == 6'd31)
                    begin
                        achieved_q <= {quo_q[30:0], ge};
                        dv_q <= DV_IDLE;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Packetization timer
    // ----------------------------------------
    logic [35:0] char_clks;
    logic [35:0] bit_cnt_q;
    logic [7:0] char_cnt_q;
    logic pending_q;

    assign char_clks = 36'(div_q) * 36'(parity_select_q == 8'd0 ? CHAR_BITS : CHAR_BITS_PAR);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bit_cnt_q <= '0;
            char_cnt_q <= 8'd0;
            pending_q <= 1'b0;
            pkt_send <= 1'b0;
        end
        else
        begin
            pkt_send <= 1'b0;
            if (ser_rx_char)
            begin
                bit_cnt_q <= '0;
                char_cnt_q <= 8'd0;
                pending_q <= packet_idle_timeout_q != 8'd0;
                pkt_send <= packet_idle_timeout_q == 8'd0;
            end
            else if (pending_q)
            begin
                if (bit_cnt_q + 36'd1 >= char_clks)
                begin
                    bit_cnt_q <= '0;
                    char_cnt_q <= char_cnt_q + 8'd1;
                    if (char_cnt_q + 8'd1 >= packet_idle_timeout_q)
                    begin
                        pending_q <= 1'b0;
                        pkt_send <= 1'b1;
                    end
                end
                else
                    bit_cnt_q <= bit_cnt_q + 36'd1;
            end
        end
    end

    // ----------------------------------------
    // Millisecond and period ticks
    // ----------------------------------------
    logic [31:0] ms_cnt_q;
    logic [3:0] ten_cnt_q;
    logic ms_tick, ten_tick;

    assign ms_tick = ms_cnt_q == 32'(MS_CLKS - 1);
    assign ten_tick = ms_tick && ten_cnt_q == 4'(PERIOD_MS - 1);

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ms_cnt_q <= 32'd0;
            ten_cnt_q <= 4'd0;
        end
        else
        begin
            ms_cnt_q <= ms_tick ? 32'd0 : ms_cnt_q + 32'd1;
            if (ms_tick)
                ten_cnt_q <= ten_tick ? 4'd0 : ten_cnt_q + 4'd1;
        end
    end

    // ----------------------------------------
    // Sleep control
    // ----------------------------------------
    typedef enum {SL_AWAKE, SL_CYC, SL_PIN} slphc_sl_t;
    slphc_sl_t sl_q;
    logic pin_m_q, pin_q, traffic, cyc_mode, pin_mode;
    logic [15:0] idle_cnt_q, slp_cnt_q, slp_len;

    assign traffic = ser_rx_char | ser_tx_char | rf_rx_frame | rf_tx_frame;
    assign cyc_mode = sleep_mode_select_q == MODE_CYC ||
        sleep_mode_select_q == MODE_CYC_PIN;
    assign pin_mode = sleep_mode_select_q == MODE_HIB ||
        sleep_mode_select_q == MODE_DOZE;
    assign slp_len = (assoc_enabled && !associated) ?
        unjoined_sleep_period_q : cyclic_sleep_period_q;
    assign asleep = sl_q != SL_AWAKE;
    assign deep_sleep = sl_q == SL_PIN && sleep_mode_select_q == MODE_HIB;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_m_q <= 1'b0;
            pin_q <= 1'b0;
        end
        else
        begin
            pin_m_q <= sleep_request_pin;
            pin_q <= pin_m_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            idle_cnt_q <= 16'd0;
        else if (traffic || sl_q != SL_AWAKE || !cyc_mode)
            idle_cnt_q <= 16'd0;
        else if (ms_tick && idle_cnt_q != 16'hFFFF)
            idle_cnt_q <= idle_cnt_q + 16'd1;
    end

    // Mode 3 and 6 never sleep here
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sl_q <= SL_AWAKE;
            slp_cnt_q <= 16'd0;
            poll_req <= 1'b0;
            sample_req <= 1'b0;
        end
        else
        begin
            poll_req <= 1'b0;
            sample_req <= 1'b0;
            unique case (sl_q)
                SL_AWAKE:
                    if (pin_mode && pin_q)
                        sl_q <= SL_PIN;
                    else if (cyc_mode && !is_coordinator && slp_len != 16'd0 &&
                             idle_cnt_q >= idle_before_sleep_time_q)
                    begin
                        sl_q <= SL_CYC;
                        slp_cnt_q <= 16'd0;
                    end
                SL_PIN:
                    if (!pin_q || !pin_mode)
                    begin
                        sl_q <= SL_AWAKE;
                        sample_req <= sampling_en && !sleep_option_bits_q[OPT_NO_SAMPLE];
                    end
                SL_CYC:
                begin
                    if (ten_tick)
                        slp_cnt_q <= slp_cnt_q + 16'd1;
                    if ((ten_tick && slp_cnt_q + 16'd1 >= slp_len) || !cyc_mode ||
                        (sleep_mode_select_q == MODE_CYC_PIN && !pin_q))
                    begin
                        sl_q <= SL_AWAKE;
                        poll_req <= !sleep_option_bits_q[OPT_NO_POLL];
                        sample_req <= sampling_en && !sleep_option_bits_q[OPT_NO_SAMPLE];
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Indirect message hold (coordinator)
    // ----------------------------------------
    // One message tracked; a new queue event restarts the hold
    logic hold_q;
    logic [17:0] hold_cnt_q, hold_len;

    assign hold_len = (18'(cyclic_sleep_period_q) * 18'd5) >> 1;

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_q <= 1'b0;
            hold_cnt_q <= 18'd0;
            ind_discard <= 1'b0;
        end
        else
        begin
            ind_discard <= 1'b0;
            if (ind_msg_queued && is_coordinator && !direct_msgs)
            begin
                hold_q <= 1'b1;
                hold_cnt_q <= 18'd0;
            end
            else if (ind_msg_taken || !is_coordinator || direct_msgs)
                hold_q <= 1'b0;
            else if (hold_q && ten_tick)
            begin
                hold_cnt_q <= hold_cnt_q + 18'd1;
                if (hold_cnt_q + 18'd1 >= hold_len)
                begin
                    hold_q <= 1'b0;
                    ind_discard <= 1'b1;
                end
            end
        end
    end
endmodule // slphc_core
`default_nettype wire

// ---- slphc_asserts.sv ----
// Checker: port assertions for the sleep and host serial config block
`timescale 1ns/1ps
`default_nettype none
module slphc_asserts (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire slphc_pkg::slphc_cfg_t cfg_req,
    input wire logic cfg_err,
    input wire logic direct_msgs,
    input wire logic legacy_coord,
    input wire logic [1:0] framing_mode,
    input wire logic [2:0] parity_mode,
    input wire logic [7:0] line_pullups
);
    import slphc_pkg::*;
    // ----------------------------------------
    // Config write effects
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire logic w_on = cfg_req.wr;
    chk_mode_legacy: assert property (w_on && cfg_req.sel == SEL_SLEEP_MODE &&
        cfg_req.data == 32'h0000_0006 |=> legacy_coord) else $error("legacy flag missing");
    chk_mode_rsvd: assert property (w_on && cfg_req.sel == SEL_SLEEP_MODE &&
        cfg_req.data == 32'h0000_0003 |=> cfg_err) else $error("mode 3 not refused");
    chk_parity_set: assert property (w_on && cfg_req.sel == SEL_PARITY &&
        cfg_req.data <= 32'h0000_0004 |=> parity_mode == $past(cfg_req.data[2:0]))
        else $error("parity not applied");
    chk_parity_bad: assert property (w_on && cfg_req.sel == SEL_PARITY &&
        cfg_req.data > 32'h0000_0004 |=> cfg_err ##0 $stable(parity_mode))
        else $error("bad parity taken");
    chk_framing_set: assert property (w_on && cfg_req.sel == SEL_FRAMING &&
        cfg_req.data <= 32'h0000_0002 |=> framing_mode == $past(cfg_req.data[1:0]))
        else $error("framing not applied");
    chk_pullup_set: assert property (w_on && cfg_req.sel == SEL_PULLUP &&
        cfg_req.data <= 32'h0000_00FF |=> line_pullups == $past(cfg_req.data[7:0]))
        else $error("pullups not applied");
    chk_period_max: assert property (w_on && cfg_req.sel == SEL_CYC_PERIOD &&
        cfg_req.data > 32'h0000_68B0 |=> cfg_err) else $error("long period taken");
    chk_direct_zero: assert property (w_on && cfg_req.sel == SEL_CYC_PERIOD &&
        cfg_req.data == 32'h0000_0000 |=> direct_msgs) else $error("direct flag missing");
    chk_rate_gap: assert property (w_on && cfg_req.sel == SEL_SER_RATE &&
        cfg_req.data inside {[32'h0000_0008 : 32'h0000_007F]} |=> cfg_err)
        else $error("rate gap taken");
    cov_refused: cover property (w_on ##1 cfg_err);
    cov_legacy: cover property ($rose(legacy_coord));
    cov_direct: cover property ($rose(direct_msgs));
endmodule // slphc_asserts
bind slphc_core slphc_asserts u_chk (.sys_clk, .rst_b, .cfg_req, .cfg_err, .direct_msgs,
    .legacy_coord, .framing_mode, .parity_mode, .line_pullups);
`default_nettype wire

// ---- slphc_host_model.sv ----
// Host model: issues config accesses on the parameter port
`timescale 1ns/1ps
`default_nettype none
module slphc_host_model (
    input wire logic sys_clk,
    output var slphc_pkg::slphc_cfg_t cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_err
);
    import slphc_pkg::*;
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    initial cfg_req = '0;
    task automatic wr(input slphc_sel_t s, input logic [31:0] d, output logic e);
        @(negedge sys_clk);
        cfg_req = '{sel: s, wr: 1'b1, rd: 1'b0, data: d};
        @(negedge sys_clk);
        e = cfg_err;
        cfg_req.wr = 1'b0;
    endtask
    task automatic rd(input slphc_sel_t s, output logic [31:0] v);
        @(negedge sys_clk);
        cfg_req = '{sel: s, wr: 1'b0, rd: 1'b1, data: 32'h0000_0000};
        @(negedge sys_clk);
        cfg_req.rd = 1'b0;
        @(negedge sys_clk);
        v = cfg_rdata;
    endtask
endmodule // slphc_host_model
`default_nettype wire

// ---- slphc_tb.sv ----
// Testbench: config port and sleep behaviour checks
`timescale 1ns/1ps
`default_nettype none
module slphc_tb;
    import slphc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    slphc_cfg_t cfg_req;
    logic [31:0] cfg_rdata, bit_clks, v;
    logic cfg_err, e, asleep, deep_sleep, poll_req, sample_req, direct_msgs, ind_discard;
    logic pkt_send, legacy_coord, pr, sq;
    logic [1:0] framing_mode;
    logic [2:0] parity_mode;
    logic [7:0] line_pullups;
    logic ser_rx_char = 0, ser_tx_char = 0, rf_rx_frame = 0, rf_tx_frame = 0;
    logic sleep_request_pin = 0, is_coordinator = 0, assoc_enabled = 0, associated = 0;
    logic sampling_en = 1, ind_msg_queued = 0, ind_msg_taken = 0;
    int failures = 0, samples_checked = 0, n, cur;
    logic [31:0] rst_tab [10] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_1388,
        32'h0000_0000, 32'h0000_03E8, 32'h0000_0003, 32'h0000_0003, 32'h0000_0000,
        32'h0000_0000, 32'h0000_00FF};
    always #5 sys_clk = ~sys_clk;
    slphc_host_model host (.sys_clk, .cfg_req, .cfg_rdata, .cfg_err);
    slphc_core #(.MS_CLKS(10)) DUT (.sys_clk, .rst_b, .cfg_req, .cfg_rdata, .cfg_err,
        .ser_rx_char, .ser_tx_char, .rf_rx_frame, .rf_tx_frame, .sleep_request_pin,
        .is_coordinator, .assoc_enabled, .associated, .sampling_en, .ind_msg_queued,
        .ind_msg_taken, .asleep, .deep_sleep, .poll_req, .sample_req, .direct_msgs,
        .ind_discard, .pkt_send, .legacy_coord, .bit_clks, .framing_mode, .parity_mode,
        .line_pullups);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x)
        begin
            $display("ERROR %s expected %h seen %h", nm, x, s);
            failures++;
        end
    endtask
    task automatic complete_run();
        if (failures == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic pulse(ref logic p);
        @(negedge sys_clk);
        p = 1'b1;
        @(negedge sys_clk);
        p = 1'b0;
    endtask
    // Counts cycles until a pulse; bounded so a silent design cannot hang
    task automatic wait_for(ref logic p, input int lim);
        for (n = 0; n < lim && p !== 1'b1; n++)
            @(negedge sys_clk);
    endtask
    initial
    begin
        #300_000;
        failures++;
        complete_run();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (120) @(negedge sys_clk);
        for (int i = 0; i < 10; i++)
        begin
            host.rd(slphc_sel_t'(i), v);
            check("reset value", v, rst_tab[i]);
        end
        check("bit_clks 9600", bit_clks, 100_000_000 / 9600);
        cur = 0;
        for (int m = 0; m < 8; m++)
        begin
            host.wr(SEL_SLEEP_MODE, m, e);
            check("mode refuse", e, m == 3 || m > 6);
            if (m != 3 && m < 7)
                cur = m;
            host.rd(SEL_SLEEP_MODE, v);
            check("mode value", v, cur);
            check("legacy", legacy_coord, cur == 6);
        end
        for (int p = 0; p < 6; p++)
        begin
            host.wr(SEL_PARITY, p, e);
            check("parity refuse", e, p > 4);
            check("parity", parity_mode, p > 4 ? 4 : p);
        end
        for (int f = 0; f < 4; f++)
        begin
            host.wr(SEL_FRAMING, f, e);
            check("framing", {e, framing_mode}, f > 2 ? 3'b110 : f);
        end
        host.wr(SEL_PULLUP, 32'h0000_005A, e);
        check("pullups", line_pullups, 8'h5A);
        host.wr(SEL_CYC_PERIOD, 32'h0000_68B0, e);
        check("period max", e, 0);
        host.wr(SEL_CYC_PERIOD, 32'h0000_68B1, e);
        check("period over", e, 1);
        host.rd(SEL_CYC_PERIOD, v);
        check("period kept", v, 32'h0000_68B0);
        check("direct off", direct_msgs, 0);
        host.wr(SEL_CYC_PERIOD, 32'h0000_0000, e);
        check("direct on", direct_msgs, 1);
        host.wr(SEL_UNJ_PERIOD, 32'h0000_0000, e);
        check("unjoined zero", e, 1);
        host.wr(SEL_IDLE_TIME, 32'h0000_0000, e);
        check("idle zero", e, 1);
        host.wr(SEL_SER_RATE, 32'h0000_007F, e);
        check("rate gap", e, 1);
        host.wr(SEL_SER_RATE, 32'h0000_0080, e);
        repeat (120) @(negedge sys_clk);
        host.rd(SEL_SER_RATE, v);
        check("rate achieved", v, 32'h0000_0080);
        check("bit_clks 128", bit_clks, 100_000_000 / 128);
        host.wr(SEL_SER_RATE, 32'h0000_0007, e);
        repeat (120) @(negedge sys_clk);
        check("bit_clks 115200", bit_clks, 100_000_000 / 115200);
        host.wr(SEL_PARITY, 0, e);
        host.wr(SEL_PKT_IDLE, 0, e);
        pulse(ser_rx_char);
        check("pkt immediate", pkt_send, 1);
        host.wr(SEL_PKT_IDLE, 1, e);
        pulse(ser_rx_char);
        wait_for(pkt_send, 20000);
        // One char time is ten bit times at the programmed rate
        check("pkt after idle", n >= 8675 && n <= 8690, 1);
        host.wr(SEL_IDLE_TIME, 2, e);
        host.wr(SEL_CYC_PERIOD, 1, e);
        host.wr(SEL_SLEEP_OPT, 0, e);
        host.wr(SEL_SLEEP_MODE, 4, e);
        repeat (5)
        begin
            repeat (6) @(negedge sys_clk);
            pulse(rf_rx_frame);
        end
        check("awake on traffic", asleep, 0);
        wait_for(asleep, 60);
        check("sleep after idle", asleep, 1);
        wait_for(poll_req, 400);
        check("wake poll", {poll_req, sample_req}, 2'b11);
        host.wr(SEL_SLEEP_OPT, 3, e);
        {pr, sq} = 2'b00;
        repeat (400)
        begin
            @(negedge sys_clk);
            pr |= poll_req;
            sq |= sample_req;
        end
        check("wake no poll", {pr, sq}, 2'b00);
        host.wr(SEL_SLEEP_MODE, 0, e);
        repeat (60) @(negedge sys_clk);
        check("no sleep mode 0", asleep, 0);
        host.wr(SEL_SLEEP_MODE, 1, e);
        sleep_request_pin = 1'b1;
        repeat (6) @(negedge sys_clk);
        check("pin hibernate", {asleep, deep_sleep}, 2'b11);
        sleep_request_pin = 1'b0;
        host.wr(SEL_SLEEP_MODE, 0, e);
        is_coordinator = 1'b1;
        host.wr(SEL_CYC_PERIOD, 2, e);
        pulse(ind_msg_queued);
        wait_for(ind_discard, 1000);
        // Five period ticks of 100 cycles; first tick early by its phase
        check("indirect hold", n >= 401 && n <= 500, 1);
        complete_run();
    end
endmodule // slphc_tb
`default_nettype wire
